/* File: rtl/level_ctrl_defs.vh */
/*
 holds the register offsets, field positions, reset values and timing counts of the playback level control bank.
 assumes inclusion by bare name from the design files of that bank.
*/
`ifndef LEVEL_CTRL_DEFS_VH
`define LEVEL_CTRL_DEFS_VH
// byte offsets on the bus
`define OFS_SOURCE_CFG 8'h02
`define OFS_RAMP_MUTE_SLOT 8'h03
`define OFS_PLAYBACK_LEVEL 8'h04
`define OFS_OUTPUT_STAGE 8'h06
`define OFS_LEVEL_LSB 8'h13
`define OFS_RAMP_STATUS 8'h20
// reset values
`define RST_SOURCE_CFG 8'h04
`define RST_RAMP_MUTE_SLOT 8'h80
`define RST_PLAYBACK_LEVEL 8'hCF
`define RST_OUTPUT_STAGE 8'h55
`define RST_LEVEL_LSB 8'h00
`define RST_SWITCH_MULTIPLE 5'h10
`define RST_GAIN_CODE 2'h1
// field positions
`define BIT_CHANNEL_SOURCE 6
`define BIT_LEVEL_STEP_SPEED 6
`define BIT_MUTE 4
`define SLOT_MSB 2
`define SLOT_LSB 0
`define BIT_DOUBLE_SPEED 3
`define RATE_MSB 6
`define RATE_LSB 4
`define GAIN_MSB 3
`define GAIN_LSB 2
`define BIT_LEVEL_LSB 0
// timing and level constants
`define SLOW_STEP_FRAMES 4'h8
`define MUTE_FLOOR 9'h008
`define LEVEL_BOTTOM 9'h000
`endif

/* File: rtl/frame_edge_sync.v */
/*
 holds a two-flop synchroniser for the frame clock pin and a rising-edge pulse.
 assumes the frame clock is far slower than mclk.
*/
`timescale 1ns/100ps
module frame_edge_sync (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // frame clock pin and its edge
   input wire frameClk,
   output reg frameTick
);
   reg meta_r;
   reg sync_r;
   reg last_r;
   // two flops, then edge detect on the second only
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
         frameTick <= 1'b0;
      end else begin
         meta_r <= frameClk;
         sync_r <= meta_r;
         last_r <= sync_r;
         frameTick <= sync_r & ~last_r;
      end
   end
endmodule // frame_edge_sync

/* File: rtl/volume_mute_gain_control.v */
/*
 holds the ramp, mute, slot, volume, switching rate and gain register bank with a classic wishbone slave.
 assumes a 50 MHz mclk, a frame clock pin from outside, and the bus device id as a static input.
*/
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "level_ctrl_defs.vh"
module volume_mute_gain_control #(
   parameter SLOT_W = 3
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // wishbone slave
   input wire wbCyc,
   input wire wbStb,
   input wire wbWe,
   input wire [7:0] wbAdr,
   input wire [3:0] wbSel,
   input wire [31:0] wbDatI,
   output reg [31:0] wbDatO,
   output reg wbAck,
   // audio side
   input wire frameClk,
   input wire [SLOT_W-1:0] busDeviceId,
   // controls to the datapath
   output reg [8:0] appliedLevel,
   output reg outputMuted,
   output reg idleAudio,
   output reg [SLOT_W-1:0] playSlot,
   output reg [4:0] switchMultiple,
   output reg [1:0] gainCode
);
   reg [7:0] sourceCfg_r;
   reg [7:0] rampMuteSlot_r;
   reg [7:0] playbackLevel_r;
   reg [7:0] outputStage_r;
   reg [7:0] levelLsb_r;
   reg [8:0] current_r;
   reg [8:0] current_nxt;
   reg [3:0] frameCnt_r;
   reg [3:0] frameCnt_nxt;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [7:0] rdData;
   reg [SLOT_W-1:0] idMeta_r;
   reg [SLOT_W-1:0] idSync_r;
   wire frameTick;
   wire [8:0] target;
   wire stepNow;
   wire access;
   localparam ST_PLAY = 2'h0;
   localparam ST_RAMP_DOWN = 2'h1;
   localparam ST_IDLE = 2'h2;
   localparam ST_RAMP_UP = 2'h3;

   // single-speed multiple per rate code; halved at double speed
   function [4:0] multipleOf;
      input [2:0] code;
      input dbl;
      reg [4:0] m;
      begin
         case (code)
            3'h0: m = 5'h06;
            3'h1: m = 5'h08;
            3'h2: m = 5'h0A;
            3'h3: m = 5'h0C;
            3'h4: m = 5'h0E;
            3'h5: m = 5'h10;
            3'h6: m = 5'h14;
            default: m = 5'h18;
         endcase
         multipleOf = dbl ? {1'b0, m[4:1]} : m;
      end
   endfunction

   frame_edge_sync uSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .frameClk(frameClk),
      .frameTick(frameTick)
   );

   // nine-bit programmed level, upper bits from the level register
   assign target = {playbackLevel_r, levelLsb_r[`BIT_LEVEL_LSB]};
   assign access = wbCyc & wbStb & ~wbAck;

   // step pacing: every frame or every eighth frame
   assign stepNow = frameTick & (rampMuteSlot_r[`BIT_LEVEL_STEP_SPEED] ||
                    frameCnt_r == `SLOW_STEP_FRAMES - 4'h1);

   // ramp state machine
   always @* begin
      state_nxt = state_r;
      current_nxt = current_r;
      frameCnt_nxt = frameCnt_r;
      if (frameTick) begin
         frameCnt_nxt = stepNow ? 4'h0 : frameCnt_r + 4'h1;
      end
      case (state_r)
         ST_PLAY: begin
            current_nxt = target;
            if (rampMuteSlot_r[`BIT_MUTE]) begin
               state_nxt = ST_RAMP_DOWN;
               frameCnt_nxt = 4'h0;
            end
         end
         ST_RAMP_DOWN: begin
            if (!rampMuteSlot_r[`BIT_MUTE]) begin
               state_nxt = ST_RAMP_UP;
            end else if (current_r == `LEVEL_BOTTOM) begin
               state_nxt = ST_IDLE;
            end else if (stepNow) begin
               current_nxt = current_r - 9'h001;
            end
         end
         ST_IDLE: begin
            if (!rampMuteSlot_r[`BIT_MUTE]) begin
               state_nxt = ST_RAMP_UP;
               frameCnt_nxt = 4'h0;
            end
         end
         default: begin
            if (rampMuteSlot_r[`BIT_MUTE]) begin
               state_nxt = ST_RAMP_DOWN;
            end else if (current_r >= target) begin
               state_nxt = ST_PLAY;
               current_nxt = target;
            end else if (stepNow) begin
               current_nxt = current_r + 9'h001;
            end
         end
      endcase
   end

   // read mux
   always @* begin
      if (wbAdr == `OFS_SOURCE_CFG) begin
         rdData = sourceCfg_r;
      end else if (wbAdr == `OFS_RAMP_MUTE_SLOT) begin
         rdData = rampMuteSlot_r;
      end else if (wbAdr == `OFS_PLAYBACK_LEVEL) begin
         rdData = playbackLevel_r;
      end else if (wbAdr == `OFS_OUTPUT_STAGE) begin
         rdData = outputStage_r;
      end else if (wbAdr == `OFS_LEVEL_LSB) begin
         rdData = levelLsb_r;
      end else if (wbAdr == `OFS_RAMP_STATUS) begin
         rdData = {5'h00, state_r == ST_IDLE, current_r[8], current_r == target};
      end else begin
         rdData = 8'h00;
      end
   end

   // bus registers, ack one cycle after the strobe
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sourceCfg_r <= `RST_SOURCE_CFG;
         rampMuteSlot_r <= `RST_RAMP_MUTE_SLOT;
         playbackLevel_r <= `RST_PLAYBACK_LEVEL;
         outputStage_r <= `RST_OUTPUT_STAGE;
         levelLsb_r <= `RST_LEVEL_LSB;
         wbAck <= 1'b0;
         wbDatO <= 32'h00000000;
      end else begin
         wbAck <= access;
         if (access && !wbWe) begin
            wbDatO <= {24'h000000, rdData};
         end
         // reserved bits stored as written; software keeps their values
         if (access && wbWe && wbSel[0]) begin
            if (wbAdr == `OFS_SOURCE_CFG) begin
               sourceCfg_r <= wbDatI[7:0];
            end else if (wbAdr == `OFS_RAMP_MUTE_SLOT) begin
               rampMuteSlot_r <= wbDatI[7:0];
            end else if (wbAdr == `OFS_PLAYBACK_LEVEL) begin
               playbackLevel_r <= wbDatI[7:0];
            end else if (wbAdr == `OFS_OUTPUT_STAGE) begin
               outputStage_r <= wbDatI[7:0];
            end else if (wbAdr == `OFS_LEVEL_LSB) begin
               levelLsb_r <= wbDatI[7:0];
            end
         end
      end
   end

   // device id pins pass two flops before the slot choice reads them
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idMeta_r <= {SLOT_W{1'b0}};
         idSync_r <= {SLOT_W{1'b0}};
      end else begin
         idMeta_r <= busDeviceId;
         idSync_r <= idMeta_r;
      end
   end

   // ramp state and outputs
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_PLAY;
         current_r <= {`RST_PLAYBACK_LEVEL, 1'b0};
         frameCnt_r <= 4'h0;
         appliedLevel <= {`RST_PLAYBACK_LEVEL, 1'b0};
         outputMuted <= 1'b0;
         idleAudio <= 1'b0;
         playSlot <= {SLOT_W{1'b0}};
         switchMultiple <= `RST_SWITCH_MULTIPLE;
         gainCode <= `RST_GAIN_CODE;
      end else begin
         state_r <= state_nxt;
         current_r <= current_nxt;
         frameCnt_r <= frameCnt_nxt;
         appliedLevel <= current_nxt;
         outputMuted <= current_nxt < `MUTE_FLOOR;
         idleAudio <= state_nxt == ST_IDLE;
         playSlot <= sourceCfg_r[`BIT_CHANNEL_SOURCE] ?
                     rampMuteSlot_r[`SLOT_MSB:`SLOT_LSB] : idSync_r;
         switchMultiple <= multipleOf(outputStage_r[`RATE_MSB:`RATE_LSB],
                                      sourceCfg_r[`BIT_DOUBLE_SPEED]);
         gainCode <= outputStage_r[`GAIN_MSB:`GAIN_LSB];
      end
   end
endmodule // volume_mute_gain_control

/* File: testbench/level_ctrl_assertions.sv */
/* checker for the level control bank: bus answer, ramp steps, mute flags, rate codes.
 assumes it is bound to volume_mute_gain_control and sees only its ports. */
`timescale 1ns/100ps
module level_ctrl_assertions #(parameter SLOT_W = 3) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // bus
   input wire wbCyc,
   input wire wbStb,
   input wire wbWe,
   input wire [7:0] wbAdr,
   input wire [3:0] wbSel,
   input wire [31:0] wbDatI,
   input wire [31:0] wbDatO,
   input wire wbAck,
   // audio side and controls
   input wire frameClk,
   input wire [SLOT_W-1:0] busDeviceId,
   input wire [8:0] appliedLevel,
   input wire outputMuted,
   input wire idleAudio,
   input wire [SLOT_W-1:0] playSlot,
   input wire [4:0] switchMultiple,
   input wire [1:0] gainCode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic fcQ;
   logic [3:0] sinceRise;
   // cycles since the frame clock last rose, saturating at 15
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fcQ <= 1'b0;
         sinceRise <= 4'hF;
      end else begin
         fcQ <= frameClk;
         sinceRise <= (frameClk && !fcQ) ? 4'h0 : sinceRise + {3'h0, sinceRise != 4'hF};
      end
   end
   a_ack_answers: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("no ack");
   a_ack_single: assert property (wbAck |=> !wbAck) else $error("ack too long");
   a_read_high_zero: assert property (wbAck && !wbWe |-> wbDatO[31:8] == 24'h0) else $error("high bits");
   a_idle_at_floor: assert property (idleAudio |-> appliedLevel == 9'h000 && outputMuted)
      else $error("idle above floor");
   a_muted_flag: assert property ($stable(appliedLevel) ##1 $stable(appliedLevel)
      |-> outputMuted == (appliedLevel < 9'h008)) else $error("muted flag wrong");
   a_ramp_unit: assert property (!$past(wbAck) && !$past(wbAck, 2) && $changed(appliedLevel)
      |-> appliedLevel + 9'h1 == $past(appliedLevel) || appliedLevel == $past(appliedLevel) + 9'h1)
      else $error("ramp step not one code");
   a_ramp_on_frame: assert property (!$past(wbAck) && !$past(wbAck, 2) && $changed(appliedLevel)
      |-> sinceRise <= 4'h8) else $error("step without frame");
   a_rate_legal: assert property (switchMultiple inside {[5'h03:5'h08], 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18})
      else $error("illegal multiple");
endmodule // level_ctrl_assertions
bind volume_mute_gain_control level_ctrl_assertions #(.SLOT_W(SLOT_W)) chkr (.*);

/* File: testbench/tb_top.sv */
/* self-checking bench for the level control bank.
 assumes the bank acks each bus request and updates its outputs a few cycles later. */
`timescale 1ns/100ps
module tb_top;
   // design signals
   logic mclk = 0, reset_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, frameClk = 0, wbAck, outputMuted, idleAudio;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'hF;
   logic [31:0] wbDatI = 32'h0, wbDatO;
   logic [8:0] appliedLevel;
   logic [2:0] playSlot, busDeviceId = 3'h5;
   logic [4:0] switchMultiple;
   logic [1:0] gainCode;
   int n_errors = 0, check_count = 0, n;
   logic [7:0] expQ[$];
   logic [7:0] s, v, e;
   logic [4:0] mult [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
   volume_mute_gain_control #(.SLOT_W(3)) dut (.*);
   always #10 mclk = ~mclk;
   // slow frame clock, 32 mclk periods
   always begin
      repeat (16) @(posedge mclk);
      frameClk <= ~frameClk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // waits for outputs to settle, then samples the named output; other names compare the value given
   task automatic chk(input string nm, input logic [8:0] ex, input logic [8:0] got);
      repeat (2) @(posedge mclk);
      #1;
      if (nm == "level") got = appliedLevel;
      else if (nm == "mult") got = 9'(switchMultiple);
      else if (nm == "gain") got = 9'(gainCode);
      else if (nm == "slot") got = 9'(playSlot);
      else if (nm == "muted") got = 9'(outputMuted);
      else if (nm == "idle") got = 9'(idleAudio);
      check_count++;
      if (got !== ex) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wbCyc <= 1;
      wbStb <= 1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= {24'h0, d};
      do @(posedge mclk); while (wbAck !== 1'b1);
      wbCyc <= 0;
      wbStb <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      expQ.push_back(ex);
      bus(0, a, 8'h00);
   endtask
   task automatic waitLevel(input logic [8:0] t);
      n = 0;
      while (appliedLevel !== t && n < 20000) begin
         @(posedge mclk);
         n++;
      end
   endtask
   // read data checked against the oldest note
   always @(posedge mclk) begin
      if (wbAck === 1'b1 && !wbWe) begin
         e = expQ.size() ? expQ.pop_front() : 8'hXX;
         check_count++;
         if (wbDatO[7:0] !== e) begin
            n_errors++;
            $display("BAD rdata exp %h got %h", e, wbDatO[7:0]);
         end
      end
   end
   // hang guard
   initial begin
      #(20 * 40000);
      n_errors++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      void'($urandom(89616));
      repeat (5) @(posedge mclk);
      reset_n <= 1;
      rd(8'h02, 8'h04);
      rd(8'h03, 8'h80);
      rd(8'h04, 8'hCF);
      rd(8'h06, 8'h55);
      rd(8'h13, 8'h00);
      rd(8'h20, 8'h03);
      rd(8'h7F, 8'h00);
      chk("level", 9'h19E, appliedLevel);
      chk("mult", 9'h010, switchMultiple);
      chk("gain", 9'h001, gainCode);
      chk("slot", busDeviceId, playSlot);
      $display("test reset done");
      s = {5'h10, busDeviceId + 3'($urandom_range(6, 1))};
      bus(1, 8'h03, s);
      chk("slot", busDeviceId, playSlot);
      bus(1, 8'h02, 8'h40);
      chk("slot", s[2:0], playSlot);
      for (int c = 0; c < 16; c++) begin
         v = $urandom;
         bus(1, 8'h02, {4'h4, c[3], 3'h0});
         bus(1, 8'h06, {1'b0, c[2:0], v[1:0], 2'b01});
         chk("mult", mult[c[2:0]] >> c[3], switchMultiple);
         chk("gain", v[1:0], gainCode);
      end
      $display("test slot and rate done");
      v = $urandom_range(255, 8);
      bus(1, 8'h04, v);
      bus(1, 8'h13, 8'h01);
      chk("level", {v, 1'b1}, appliedLevel);
      chk("muted", 9'h0, outputMuted);
      bus(1, 8'h04, 8'h03);
      chk("muted", 9'h1, outputMuted);
      bus(1, 8'h13, 8'h00);
      bus(1, 8'h04, 8'h04);
      chk("muted", 9'h0, outputMuted);
      // a write without its low byte lane selected must leave the level alone
      @(posedge mclk);
      wbSel <= 4'hE;
      bus(1, 8'h04, 8'h55);
      wbSel <= 4'hF;
      chk("level", 9'h008, appliedLevel);
      $display("test volume done");
      bus(1, 8'h04, 8'h08);
      bus(1, 8'h03, 8'hD0);
      waitLevel(9'h000);
      chk("fast down", 9'h1, 9'(n > 440 && n < 620));
      chk("idle", 9'h1, idleAudio);
      rd(8'h20, 8'h04);
      bus(1, 8'h03, 8'hC0);
      waitLevel(9'h010);
      chk("fast up", 9'h1, 9'(n > 440 && n < 620));
      bus(1, 8'h04, 8'h02);
      bus(1, 8'h03, 8'h90);
      waitLevel(9'h000);
      chk("slow down", 9'h1, 9'(n > 900 && n < 1250));
      $display("test ramp done");
      tally_and_finish;
   end
endmodule // tb_top
